// >>> verification/pdrm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdrm_host_model
   import pdrm_pkg::*;
(
   input  wire logic        clk_sys,   // clock
   output var  logic [15:0] cfgAddr,   // address
   output var  logic        cfgWrEn,   // write strobe
   output var  logic [7:0]  cfgWrData, // write byte
   output var  logic        cfgRdEn,   // read strobe
   input  wire logic [7:0]  cfgRdData  // read byte
);
   // writable bits; the host always sends reserved bits as zero
   function automatic logic [7:0] wrMask(input logic [15:0] a);
      case (a)
         OFS_LOCK_DBL: return 8'h30;
         OFS_REF_OFF: return 8'h03;
         OFS_PAIR_OFF: return 8'h0F;
         OFS_CORE_OFF: return 8'h07;
         OFS_REF0_HI, OFS_REF1_HI: return 8'h01;
         OFS_STICKY: return 8'h43;
         OFS_REF0_MID, OFS_REF0_LO, OFS_REF1_MID, OFS_REF1_LO: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction
   initial begin
      cfgAddr = 16'h0000;
      cfgWrEn = 1'b0;
      cfgWrData = 8'h00;
      cfgRdEn = 1'b0;
   end
   // one byte access; released lines never keep the last value
   task automatic xfer(input logic wr, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      @(negedge clk_sys);
      cfgAddr = a;
      cfgWrData = d & wrMask(a);
      cfgWrEn = wr;
      cfgRdEn = !wr;
      @(posedge clk_sys);
      @(negedge clk_sys);
      q = cfgRdData;
      cfgWrEn = 1'b0;
      cfgRdEn = 1'b0;
      cfgAddr = ~a;
      cfgWrData = ~cfgWrData;
   endtask
endmodule // pdrm_host_model
`default_nettype wire

// >>> verification/pdrm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pdrm_properties
   import pdrm_pkg::*;
#(parameter int LIMIT_W = 17) (
   input wire logic        clk_sys,             // clock
   input wire logic        rst_n,               // reset
   input wire logic        ce,                  // enable
   input wire logic [15:0] cfgAddr,             // address
   input wire logic        cfgWrEn,             // write
   input wire logic [7:0]  cfgWrData,           // data
   input wire logic [1:0]  refIn,               // refs
   input wire logic        pllLocked,           // lock
   input wire logic        outputsStable,       // stable
   input wire logic [3:0]  pairClkOut,          // pair clocks
   input wire logic [3:0]  pairDrvOeN,          // high-Z
   input wire logic        lockReleaseMode,     // mode
   input wire logic        crystalDoublerOn,    // doubler
   input wire logic [1:0]  inputReferenceOff,   // ref off
   input wire logic [3:0]  outputPairOff,       // pair off
   input wire logic        digitalLoopOff,      // loop off
   input wire logic        modulatorOff,        // mod off
   input wire logic        calibrationHold,     // cal hold
   input wire logic        lossOfLockAlarm,     // lock alarm
   input wire logic [1:0]  missingReferenceAlarm // miss alarms
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // a write counts only with the clock enable up
   wire wrStb = ce && cfgWrEn;
   property p_pair; wrStb && cfgAddr == OFS_PAIR_OFF |=>
      outputPairOff == $past(cfgWrData[3:0]); endproperty
   a_pair: assert property (p_pair) else $error("pair disable");
   property p_oe; pairDrvOeN == outputPairOff; endproperty
   a_oe: assert property (p_oe) else $error("driver enable");
   property p_gate; ce |=> (pairClkOut & $past(outputPairOff)) == 4'h0;
   endproperty
   a_gate: assert property (p_gate) else $error("pair not gated");
   property p_lock; wrStb && cfgAddr == OFS_LOCK_DBL |=>
      lockReleaseMode == $past(cfgWrData[BIT_LOCK_MODE]) &&
      crystalDoublerOn != $past(cfgWrData[BIT_DBL_BYP]); endproperty
   a_lock: assert property (p_lock) else $error("mode or doubler");
   property p_ref; wrStb && cfgAddr == OFS_REF_OFF |=>
      inputReferenceOff == $past(cfgWrData[1:0]); endproperty
   a_ref: assert property (p_ref) else $error("ref disable");
   property p_core; wrStb && cfgAddr == OFS_CORE_OFF |=>
      {digitalLoopOff, modulatorOff, calibrationHold} == $past(cfgWrData[2:0]);
   endproperty
   a_core: assert property (p_core) else $error("core bits");
   property p_lolClr; ce && pllLocked && (!lockReleaseMode || outputsStable)
      |=> !lossOfLockAlarm; endproperty
   a_lolClr: assert property (p_lolClr) else $error("lock alarm held");
   property p_lolSet; ce && !pllLocked |=> lossOfLockAlarm; endproperty
   a_lolSet: assert property (p_lolSet) else $error("lock alarm low");
   property p_lolWait; ce && lockReleaseMode && !outputsStable &&
      lossOfLockAlarm |=> lossOfLockAlarm; endproperty
   a_lolWait: assert property (p_lolWait) else $error("released early");
   property p_missDrop; ce && $past(ce) && $rose(refIn[0]) ##1 ce |=>
      !missingReferenceAlarm[0]; endproperty
   a_missDrop: assert property (p_missDrop) else $error("no restart");
endmodule // pdrm_properties
bind pdrm_power_ref_ctrl pdrm_properties #(.LIMIT_W(LIMIT_W))
   pdrm_properties_inst (.*);
`default_nettype wire

// >>> verification/test_power_down_and_ref_monitor_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_power_down_and_ref_monitor_ctrl;
   import pdrm_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1;
   logic pllLocked = 1'b0, outputsStable = 1'b0;
   logic [1:0] refIn = 2'b00, inputReferenceOff, missingReferenceAlarm;
   logic [3:0] pairClkIn = 4'h0, pairClkOut, pairDrvOeN, outputPairOff;
   logic [15:0] cfgAddr;
   logic [7:0] cfgWrData, cfgRdData, q;
   logic cfgWrEn, cfgRdEn, lockReleaseMode, crystalDoublerOn, digitalLoopOff;
   logic modulatorOff, calibrationHold, lossOfLockAlarm;
   int nErrors = 0, nCompared = 0, seed = 32'hd0a16147, k, n, d;
   int lim [2];
   logic [7:0] mdl [int]; // register image kept from the writes
   always #5 clk_sys = ~clk_sys;
   always @(negedge clk_sys) pairClkIn = 4'($random(seed));
   pdrm_power_ref_ctrl pdrm_power_ref_ctrl_inst (.clk_sys, .rst_n, .ce,
      .cfgAddr, .cfgWrEn, .cfgWrData, .cfgRdEn, .cfgRdData, .refIn,
      .pllLocked, .outputsStable, .pairClkIn, .pairClkOut, .pairDrvOeN,
      .lockReleaseMode, .crystalDoublerOn, .inputReferenceOff,
      .outputPairOff, .digitalLoopOff, .modulatorOff, .calibrationHold,
      .lossOfLockAlarm, .missingReferenceAlarm);
   pdrm_host_model pdrm_host_model_inst (.clk_sys, .cfgAddr, .cfgWrEn,
      .cfgWrData, .cfgRdEn, .cfgRdData);
   function automatic logic [7:0] ex(input int a);
      return mdl.exists(a) ? mdl[a] : 8'h00;
   endfunction
   task automatic check(input string what, input logic [31:0] e, got);
      nCompared++;
      if (got !== e) begin
         nErrors++;
         $display("wrong value %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic wr(input int a, input logic [7:0] v);
      pdrm_host_model_inst.xfer(1'b1, a[15:0], v, q);
      mdl[a] = v & pdrm_host_model_inst.wrMask(a[15:0]);
   endtask
   task automatic rd(input int a, input logic [7:0] e);
      pdrm_host_model_inst.xfer(1'b0, a[15:0], 8'h00, q);
      check("read", e, q);
   endtask
   // control outputs against the image
   task automatic outChk();
      check("pairs", ex(OFS_PAIR_OFF), outputPairOff);
      check("pairOe", ex(OFS_PAIR_OFF), pairDrvOeN);
      check("refs", ex(OFS_REF_OFF), inputReferenceOff);
      check("lock", ex(OFS_LOCK_DBL) ^ 8'h10,
         {lockReleaseMode, crystalDoublerOn, 4'h0});
      check("core", ex(OFS_CORE_OFF),
         {digitalLoopOff, modulatorOff, calibrationHold});
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", nCompared, nErrors);
      if (nErrors == 0 && nCompared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog: the sequence needs a few hundred cycles
   initial begin
      #200us;
      nErrors++;
      complete_run();
   end
   initial begin
      for (k = 0; k < 2; k++) begin
         mdl[16'h71 + 3 * k] = 8'h01;
         mdl[16'h72 + 3 * k] = 8'hFF;
         mdl[16'h73 + 3 * k] = 8'hFF;
      end
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      // defaults, reserved places and one unmapped place
      for (k = 16'h6C; k <= 16'h79; k++) rd(k, ex(k));
      outChk();
      repeat (4) for (k = 16'h6C; k <= 16'h70; k++) begin
         d = $random(seed);
         wr(k, d[7:0]);
         rd(k, ex(k));
         outChk();
      end
      // writes are dropped while the enable is low
      ce = 1'b0;
      pdrm_host_model_inst.xfer(1'b1, OFS_PAIR_OFF, ~ex(OFS_PAIR_OFF), q);
      ce = 1'b1;
      outChk();
      wr(OFS_REF_OFF, 8'h00);
      lim[0] = 3;
      lim[1] = 3 + {$random(seed)} % 30;
      for (k = 0; k < 2; k++) begin
         wr(16'h71 + 3 * k, 8'h00);
         wr(16'h72 + 3 * k, 8'h00);
         wr(16'h73 + 3 * k, lim[k][7:0]);
      end
      // a reference edge restarts the count; alarm after limit periods
      for (k = 0; k < 2; k++) begin
         refIn[k] = 1'b1;
         repeat (3) @(negedge clk_sys);
         check("missLow", 1'b0, missingReferenceAlarm[k]);
         n = 3;
         while (missingReferenceAlarm[k] !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
         end
         check("missCycles", lim[k] + 2, n);
      end
      wr(OFS_REF_OFF, 8'h03);
      repeat (3) @(negedge clk_sys);
      check("missOff", 2'b00, missingReferenceAlarm);
      rd(OFS_STICKY, 8'h03);
      wr(OFS_STICKY, 8'h03);
      rd(OFS_STICKY, 8'h00);
      wr(OFS_LOCK_DBL, 8'h20);
      pllLocked = 1'b1;
      repeat (5) @(negedge clk_sys);
      check("lolWait", 1'b1, lossOfLockAlarm);
      outputsStable = 1'b1;
      repeat (2) @(negedge clk_sys);
      check("lolStable", 1'b0, lossOfLockAlarm);
      pllLocked = 1'b0;
      outputsStable = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("lolLost", 1'b1, lossOfLockAlarm);
      rd(OFS_STICKY, 8'h40);
      wr(OFS_LOCK_DBL, 8'h00);
      pllLocked = 1'b1;
      repeat (2) @(negedge clk_sys);
      check("lolLocked", 1'b0, lossOfLockAlarm);
      wr(OFS_STICKY, 8'h40);
      rd(OFS_STICKY, 8'h00);
      complete_run();
   end
endmodule // test_power_down_and_ref_monitor_ctrl
`default_nettype wire

// >>> verilog/pdrm_pkg.sv
`default_nettype none
package pdrm_pkg;
   // register offsets on the serial configuration port
   localparam logic [15:0] OFS_LOCK_DBL  = 16'h006C;
   localparam logic [15:0] OFS_REF_OFF   = 16'h006D;
   localparam logic [15:0] OFS_RSVD_PWR  = 16'h006E;
   localparam logic [15:0] OFS_PAIR_OFF  = 16'h006F;
   localparam logic [15:0] OFS_CORE_OFF  = 16'h0070;
   localparam logic [15:0] OFS_REF0_HI   = 16'h0071;
   localparam logic [15:0] OFS_REF0_MID  = 16'h0072;
   localparam logic [15:0] OFS_REF0_LO   = 16'h0073;
   localparam logic [15:0] OFS_REF1_HI   = 16'h0074;
   localparam logic [15:0] OFS_REF1_MID  = 16'h0075;
   localparam logic [15:0] OFS_REF1_LO   = 16'h0076;
   localparam logic [15:0] OFS_RSVD_MONA = 16'h0077;
   localparam logic [15:0] OFS_RSVD_MONB = 16'h0078;
   localparam logic [15:0] OFS_STICKY    = 16'h0200;
   // field positions
   localparam int BIT_LOCK_MODE = 5;
   localparam int BIT_DBL_BYP   = 4;
   localparam int BIT_DLOOP     = 2;
   localparam int BIT_MOD       = 1;
   localparam int BIT_CAL       = 0;
   localparam int BIT_LIM_HI    = 0;
   localparam int BIT_ST_LOL    = 6;
   localparam int BIT_ST_LOS1   = 1;
   localparam int BIT_ST_LOS0   = 0;
   // reset values and the smallest miss limit
   localparam logic        RST_CTRL_BIT = 1'b0;
   localparam logic [16:0] RST_LIMIT    = 17'h1FFFF;
   localparam logic [16:0] LIMIT_MIN    = 17'h00003;
   // loss-of-lock alarm states
   typedef enum logic {PDRM_LOL_RAISED, PDRM_LOL_CLEAR} pdrm_lol_t;
endpackage
`default_nettype wire

// >>> verilog/pdrm_power_ref_ctrl.sv
// How it works
// - lock alarm release: locked, or locked+stable
// - doubler bypass bit picks 1x or 2x
// - one disable bit per input reference
// - pair disable gates logic, driver high-Z
// - digital loop off while bit set
// - modulator off while bit set
// - calibration held while bit set
// - 17-bit miss limit, three bytes, ones
// - soft miss alarm after limit periods
// - reserved bits written zero, read as zero
// - sticky alarm status, write one clears
`timescale 1ns/1ps
`default_nettype none
module pdrm_power_ref_ctrl
   import pdrm_pkg::*;
#(
   parameter int LIMIT_W = 17
) (
   input  wire  logic         clk_sys,               // system clock
   input  wire  logic         rst_n,                 // sync reset, low
   input  wire  logic         ce,                    // clock enable
   input  wire  logic [15:0]  cfgAddr,               // register address
   input  wire  logic         cfgWrEn,               // write strobe
   input  wire  logic [7:0]   cfgWrData,             // write byte
   input  wire  logic         cfgRdEn,               // read strobe
   output var   logic [7:0]   cfgRdData,             // read byte
   input  wire  logic [1:0]   refIn,                 // reference levels
   input  wire  logic         pllLocked,             // loop lock
   input  wire  logic         outputsStable,         // outputs settled
   input  wire  logic [3:0]   pairClkIn,             // per-pair clocks
   output var   logic [3:0]   pairClkOut,            // gated pair clocks
   output logic [3:0]         pairDrvOeN,            // high: driver high-Z
   output logic               lockReleaseMode,       // alarm release mode
   output logic               crystalDoublerOn,      // 2x crystal used
   output logic [1:0]         inputReferenceOff,     // reference disables
   output logic [3:0]         outputPairOff,         // pair disables
   output logic               digitalLoopOff,        // digital loop off
   output logic               modulatorOff,          // modulator off
   output logic               calibrationHold,       // calibration held
   output logic               lossOfLockAlarm,       // lock alarm
   output var   logic [1:0]   missingReferenceAlarm  // soft miss alarms
);

   // 16-bit address match, shared by every write decode
   function automatic logic hit(input logic [15:0] a,
                                input logic [15:0] ofs);
      hit = (a == ofs);
   endfunction

   // one stored bit placed at its position in a read byte
   function automatic logic [7:0] place(input logic b, input int pos);
      place = 8'(b) << pos;
   endfunction

   // control bits
   logic                lockMode_q;
   logic                dblBypass_q;
   logic [1:0]          refOff_q;
   logic [3:0]          pairOff_q;
   logic                dloopOff_q;
   logic                modOff_q;
   logic                calHold_q;
   wire  [LIMIT_W-1:0]  limVal [2];
   wire  [1:0]          missBits;
   logic [2:0]          sticky_q;
   logic [2:0]          sticky_d;
   logic [7:0]          rdData_q;
   logic [7:0]          rdMux;
   pdrm_lol_t           lolState_q;
   pdrm_lol_t           lolState_d;
   logic                lolPrev_q;
   logic [1:0]          missPrev_q;

   // write decodes
   wire wrLock   = cfgWrEn && hit(cfgAddr, OFS_LOCK_DBL);
   wire wrRefOff = cfgWrEn && hit(cfgAddr, OFS_REF_OFF);
   wire wrPair   = cfgWrEn && hit(cfgAddr, OFS_PAIR_OFF);
   wire wrCore   = cfgWrEn && hit(cfgAddr, OFS_CORE_OFF);
   wire wrSticky = cfgWrEn && hit(cfgAddr, OFS_STICKY);

   // limit byte offsets per reference, high/mid/low
   wire [15:0] limHiOfs  [2];
   wire [15:0] limMidOfs [2];
   wire [15:0] limLoOfs  [2];
   assign limHiOfs[0]  = OFS_REF0_HI;
   assign limMidOfs[0] = OFS_REF0_MID;
   assign limLoOfs[0]  = OFS_REF0_LO;
   assign limHiOfs[1]  = OFS_REF1_HI;
   assign limMidOfs[1] = OFS_REF1_MID;
   assign limLoOfs[1]  = OFS_REF1_LO;

   // field extraction from the write byte
   wire       wrModeBit  = cfgWrData[BIT_LOCK_MODE];
   wire       wrBypBit   = cfgWrData[BIT_DBL_BYP];
   wire [1:0] wrRefBits  = cfgWrData[1:0];
   wire [3:0] wrPairBits = cfgWrData[3:0];
   wire       wrLoopBit  = cfgWrData[BIT_DLOOP];
   wire       wrModBit   = cfgWrData[BIT_MOD];
   wire       wrCalBit   = cfgWrData[BIT_CAL];

   // lock release mode and doubler bypass share one byte
   // only defined fields are stored; reserved writes are dropped
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lockMode_q  <= RST_CTRL_BIT;
         dblBypass_q <= RST_CTRL_BIT;
      end else if (ce && wrLock) begin
         lockMode_q  <= wrModeBit;
         dblBypass_q <= wrBypBit;
      end
   end

   // input reference disables
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         refOff_q <= {2{RST_CTRL_BIT}};
      end else if (ce && wrRefOff) begin
         refOff_q <= wrRefBits;
      end
   end

   // output pair disables
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pairOff_q <= {4{RST_CTRL_BIT}};
      end else if (ce && wrPair) begin
         pairOff_q <= wrPairBits;
      end
   end

   // loop core disables; a held calibration leaves the loop untrimmed
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dloopOff_q <= RST_CTRL_BIT;
         modOff_q   <= RST_CTRL_BIT;
         calHold_q  <= RST_CTRL_BIT;
      end else if (ce && wrCore) begin
         dloopOff_q <= wrLoopBit;
         modOff_q   <= wrModBit;
         calHold_q  <= wrCalBit;
      end
   end

   // core enables follow the stored bits directly; the doubler enable is the inverted bypass bit
   assign lockReleaseMode   = lockMode_q;
   assign crystalDoublerOn  = ~dblBypass_q;
   assign inputReferenceOff = refOff_q;
   assign outputPairOff     = pairOff_q;
   assign pairDrvOeN        = pairOff_q;
   assign digitalLoopOff    = dloopOff_q;
   assign modulatorOff      = modOff_q;
   assign calibrationHold   = calHold_q;

   // pair clock gating; a disabled pair holds its output low
   // so nothing downstream toggles while the driver floats
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pairClkOut <= 4'h0;
      end else if (ce) begin
         pairClkOut <= pairClkIn & ~pairOff_q;
      end
   end

   // per-reference limit registers and missing-reference monitors
   // a limit below three is host misuse and is not guarded here
   genvar r;
   generate
      for (r = 0; r < 2; r++) begin : g_ref
         logic [LIMIT_W-1:0] lim_q;
         logic [LIMIT_W-1:0] cnt_q;
         logic               refPrev_q;
         logic               miss_q;
         wire                refEdge = refIn[r] & ~refPrev_q;
         wire                atLimit = (cnt_q >= lim_q);

         // byte selects for this reference's limit
         wire                wrHi  = cfgWrEn && hit(cfgAddr, limHiOfs[r]);
         wire                wrMid = cfgWrEn && hit(cfgAddr, limMidOfs[r]);
         wire                wrLo  = cfgWrEn && hit(cfgAddr, limLoOfs[r]);

         // limit split over three bytes; bit 16 alone in the high one
         // each byte lands at once, so a partial update is briefly live
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               lim_q <= LIMIT_W'(RST_LIMIT);
            end else if (ce) begin
               if (wrHi) begin
                  lim_q[16] <= cfgWrData[BIT_LIM_HI];
               end
               if (wrMid) begin
                  lim_q[15:8] <= cfgWrData;
               end
               if (wrLo) begin
                  lim_q[7:0] <= cfgWrData;
               end
            end
         end

         // counter of monitoring periods since the last edge
         // a disabled reference is held at zero and never alarms
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               cnt_q     <= '0;
               refPrev_q <= 1'b0;
            end else if (ce) begin
               refPrev_q <= refIn[r];
               if (refOff_q[r] || refEdge) begin
                  cnt_q <= '0;
               end else if (!atLimit) begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         end

         // soft alarm once the programmed periods pass with no edge
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               miss_q <= 1'b0;
            end else if (ce) begin
               miss_q <= ~refOff_q[r] & atLimit;
            end
         end

         // results leave the loop through nets, one driver each
         assign limVal[r]   = lim_q;
         assign missBits[r] = miss_q;
      end
   endgenerate

   // soft alarms gathered from both monitors
   assign missingReferenceAlarm = missBits;

   // loss-of-lock alarm; raised from reset until the loop locks (with release mode set, also until outputs settle)
   always_comb begin
      lolState_d = lolState_q;
      unique case (lolState_q)
         PDRM_LOL_RAISED: begin
            if (pllLocked && (!lockMode_q || outputsStable)) begin
               lolState_d = PDRM_LOL_CLEAR;
            end
         end
         PDRM_LOL_CLEAR: begin
            if (!pllLocked) begin
               lolState_d = PDRM_LOL_RAISED;
            end
         end
      endcase
   end

   // lock alarm state register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lolState_q <= PDRM_LOL_RAISED;
      end else if (ce) begin
         lolState_q <= lolState_d;
      end
   end

   assign lossOfLockAlarm = (lolState_q == PDRM_LOL_RAISED);

   // alarm onsets for the sticky status
   // edge-triggered so a long alarm does not refill a cleared bit
   wire lolRise      = lossOfLockAlarm & ~lolPrev_q;
   wire [1:0] losRise = missingReferenceAlarm & ~missPrev_q;
   wire [2:0] stSet  = {lolRise, losRise};
   wire [2:0] stClr  = wrSticky ?
                       {cfgWrData[BIT_ST_LOL], cfgWrData[BIT_ST_LOS1],
                        cfgWrData[BIT_ST_LOS0]} : 3'h0;

   // set beats a clear arriving in the same cycle
   assign sticky_d = (sticky_q & ~stClr) | stSet;

   // sticky status bits
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sticky_q <= 3'h0;
      end else if (ce) begin
         sticky_q <= sticky_d;
      end
   end

   // previous alarm levels for onset detection
   // lock history starts raised, like the alarm out of reset,
   // so leaving reset is not taken for a fresh loss of lock
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lolPrev_q  <= 1'b1;
         missPrev_q <= 2'h0;
      end else if (ce) begin
         lolPrev_q  <= lossOfLockAlarm;
         missPrev_q <= missingReferenceAlarm;
      end
   end

   // read fields placed at their byte positions
   wire [7:0] rdLock   = place(lockMode_q, BIT_LOCK_MODE)
                       | place(dblBypass_q, BIT_DBL_BYP);
   wire [7:0] rdCore   = place(dloopOff_q, BIT_DLOOP)
                       | place(modOff_q, BIT_MOD)
                       | place(calHold_q, BIT_CAL);
   wire [7:0] rdStk    = place(sticky_q[2], BIT_ST_LOL)
                       | place(sticky_q[1], BIT_ST_LOS1)
                       | place(sticky_q[0], BIT_ST_LOS0);
   wire [7:0] rdRef    = {6'h00, refOff_q};
   wire [7:0] rdPair   = {4'h0, pairOff_q};
   wire [7:0] rdLim0Hi = place(limVal[0][16], BIT_LIM_HI);
   wire [7:0] rdLim1Hi = place(limVal[1][16], BIT_LIM_HI);

   // read mux; reserved bits and unmapped addresses return zero
   always_comb begin
      unique case (cfgAddr)
         OFS_LOCK_DBL:  rdMux = rdLock;
         OFS_REF_OFF:   rdMux = rdRef;
         OFS_PAIR_OFF:  rdMux = rdPair;
         OFS_CORE_OFF:  rdMux = rdCore;
         OFS_REF0_HI:   rdMux = rdLim0Hi;
         OFS_REF0_MID:  rdMux = limVal[0][15:8];
         OFS_REF0_LO:   rdMux = limVal[0][7:0];
         OFS_REF1_HI:   rdMux = rdLim1Hi;
         OFS_REF1_MID:  rdMux = limVal[1][15:8];
         OFS_REF1_LO:   rdMux = limVal[1][7:0];
         OFS_STICKY:    rdMux = rdStk;
         default:       rdMux = 8'h00;
      endcase
   end

   // read data registered; answer one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdData_q <= 8'h00;
      end else if (ce && cfgRdEn) begin
         rdData_q <= rdMux;
      end
   end

   // read byte stands until the next read strobe
   assign cfgRdData = rdData_q;

endmodule // pdrm_power_ref_ctrl
`default_nettype wire
